// ### pbm_regs.sv
// PHY basic mode control, status and advertisement registers on APB
// Function
// RQ1 - Software reset restores defaults, then self-clears
// RQ2 - Speed bit: one 100 Mbps, zero 10
// RQ3 - Speed, autoneg, duplex defaults from EEPROM
// RQ4 - Autoneg enabled ignores speed select bit
// RQ5 - Autoneg off: speed and duplex follow bits
// RQ6 - Restart bit begins new negotiation
// RQ7 - Duplex bit: one full, zero half
// RQ8 - Autoneg on: duplex reads resolved status
// RQ9 - Status ability bits are fixed constants
// RQ10 - Negotiation complete reads one when finished
// RQ11 - Remote fault sets, clears on status read
// RQ12 - Link history resets one, zero after fail
// RQ13 - Link status reads valid link
// RQ14 - Jabber status reads jabber condition
// RQ15 - Extended capability reads constant one
// RQ16 - Next page and acknowledge read zero
// RQ17 - Remote fault advertise writable, resets zero
// RQ18 - Pause advertise read-only, EEPROM default
// RQ19 - Four-pair advertise reads zero, never offered
// RQ20 - Four ability advertise bits writable, reset one
// RQ21 - Selector field resets to CSMA/CD code
// RQ22 - Restart bit self-clears once negotiation begins
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps

module pbm_regs (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [pbm_pkg::ADDR_W-1:0] paddr,
    input  wire logic [pbm_pkg::DATA_W-1:0] pwdata,
    output logic      [pbm_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       link_ok_in,
    input  wire logic                       jabber_in,
    input  wire logic                       remote_fault_in,
    input  wire logic                       an_done_in,
    input  wire logic                       res_speed_100_in,
    input  wire logic                       res_full_duplex_in,
    input  wire logic                       ee_load_done_in,
    input  wire logic                       ee_speed_100_in,
    input  wire logic                       ee_autoneg_in,
    input  wire logic                       ee_full_duplex_in,
    input  wire logic                       ee_pause_in,
    output logic                            speed_100,
    output logic                            full_duplex,
    output logic                            autoneg_active,
    output logic                            autoneg_restart,
    output logic                            phy_soft_reset,
    output logic      [pbm_pkg::REG_W-1:0]  adv_word
);

    // Byte address of a register index, compared against the bus address
    function automatic logic pbm_hit(input logic [pbm_pkg::ADDR_W-1:0] a,
                                     input logic [7:0] idx);
        pbm_hit = (a == {2'h0, idx, 2'h0});
    endfunction

    // Two-stage synchroniser for all pin inputs
    logic [pbm_pkg::SYNC_W-1:0] sync1_reg;
    logic [pbm_pkg::SYNC_W-1:0] sync2_reg;
    logic                       ee_done_d_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg     <= '0;
            sync2_reg     <= '0;
            ee_done_d_reg <= 1'b0;
        end else begin
            sync1_reg     <= {link_ok_in, jabber_in, remote_fault_in,
                              an_done_in, res_speed_100_in,
                              res_full_duplex_in, ee_load_done_in,
                              ee_speed_100_in, ee_autoneg_in,
                              ee_full_duplex_in, ee_pause_in};
            sync2_reg     <= sync1_reg;
            ee_done_d_reg <= sync2_reg[4];
        end
    end

    // Named views of synchronised inputs
    wire link_s    = sync2_reg[10];
    wire jabber_s  = sync2_reg[9];
    wire rfault_s  = sync2_reg[8];
    wire an_done_s = sync2_reg[7];
    wire res_spd_s = sync2_reg[6];
    wire res_dup_s = sync2_reg[5];
    wire ee_done_s = sync2_reg[4];
    wire ee_spd_s  = sync2_reg[3];
    wire ee_ane_s  = sync2_reg[2];
    wire ee_dup_s  = sync2_reg[1];
    wire ee_pau_s  = sync2_reg[0];
    wire ee_load   = ee_done_s & ~ee_done_d_reg;

    // Bus decode and transfer strobes
    wire hit_ctrl = pbm_hit(paddr, pbm_pkg::CTRL_IDX);
    wire hit_stat = pbm_hit(paddr, pbm_pkg::STAT_IDX);
    wire hit_adv  = pbm_hit(paddr, pbm_pkg::ADV_IDX);
    wire hit_any  = hit_ctrl | hit_stat | hit_adv;
    wire access   = psel & penable & ~pready;
    wire fire     = psel & penable & pready;
    wire wr_fire  = fire & pwrite & ~pslverr;
    wire rd_fire  = fire & ~pwrite & ~pslverr;
    wire wr_ctrl  = wr_fire & hit_ctrl;
    wire wr_adv   = wr_fire & hit_adv;
    wire rd_stat  = rd_fire & hit_stat;
    wire sw_reset = wr_ctrl & pwdata[pbm_pkg::CTRL_RESET];

    // Register state
    logic                  spd_reg;
    logic                  ane_reg;
    logic                  dup_reg;
    logic                  restart_reg;
    logic                  dflt_spd_reg;
    logic                  dflt_ane_reg;
    logic                  dflt_dup_reg;
    logic                  pause_reg;
    logic                  rfadv_reg;
    logic [3:0]            abil_reg;
    logic [4:0]            sel_reg;
    logic                  rfault_reg;
    logic                  lhist_reg;
    pbm_pkg::pbm_an_state_t an_state_reg;
    pbm_pkg::pbm_an_state_t an_state_next;

    // Negotiation kick: fresh enable or restart request
    wire an_kick = ane_reg & (restart_reg | an_state_reg == pbm_pkg::PBM_AN_OFF);

    // EEPROM defaults caught after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dflt_spd_reg <= 1'b0;
            dflt_ane_reg <= 1'b0;
            dflt_dup_reg <= 1'b0;
            pause_reg    <= 1'b0;
        end else if (ee_load) begin
            dflt_spd_reg <= ee_spd_s;   // see RQ3
            dflt_ane_reg <= ee_ane_s;   // see RQ3
            dflt_dup_reg <= ee_dup_s;   // see RQ3
            pause_reg    <= ee_pau_s;   // see RQ18
        end
    end

    // Control register; soft reset wins over any other field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spd_reg     <= 1'b0;
            ane_reg     <= 1'b0;
            dup_reg     <= 1'b0;
            restart_reg <= 1'b0;
        end else if (sw_reset) begin
            spd_reg     <= dflt_spd_reg;   // see RQ1
            ane_reg     <= dflt_ane_reg;   // see RQ1
            dup_reg     <= dflt_dup_reg;   // see RQ1
            restart_reg <= 1'b0;
        end else if (ee_load) begin
            spd_reg     <= ee_spd_s;   // see RQ3
            ane_reg     <= ee_ane_s;   // see RQ3
            dup_reg     <= ee_dup_s;   // see RQ3
        end else if (wr_ctrl) begin
            spd_reg     <= pwdata[pbm_pkg::CTRL_SPEED];
            ane_reg     <= pwdata[pbm_pkg::CTRL_ANE];
            dup_reg     <= pwdata[pbm_pkg::CTRL_DUPLEX];
            restart_reg <= pwdata[pbm_pkg::CTRL_RESTART]; // see RQ6
        end else if (an_kick | ~ane_reg) begin
            restart_reg <= 1'b0;   // see RQ22
        end
    end

    // Advertisement register writable fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rfadv_reg <= 1'b0;
            abil_reg  <= pbm_pkg::ADV_ABIL_RST;
            sel_reg   <= pbm_pkg::ADV_SEL_RST;
        end else if (sw_reset) begin
            rfadv_reg <= 1'b0;                  // see RQ17
            abil_reg  <= pbm_pkg::ADV_ABIL_RST; // see RQ20
            sel_reg   <= pbm_pkg::ADV_SEL_RST;  // see RQ21
        end else if (wr_adv) begin
            rfadv_reg <= pwdata[pbm_pkg::ADV_RFAULT];
            abil_reg  <= pwdata[pbm_pkg::ADV_ABIL_HI:pbm_pkg::ADV_ABIL_LO];
            sel_reg   <= pwdata[pbm_pkg::ADV_SEL_HI:pbm_pkg::ADV_SEL_LO];
        end
    end

    // Sticky status: event wins over clear-on-read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rfault_reg <= 1'b0;
            lhist_reg  <= 1'b1;
        end else if (sw_reset) begin
            rfault_reg <= 1'b0;
            lhist_reg  <= 1'b1;
        end else begin
            rfault_reg <= rfault_s | (rfault_reg & ~rd_stat); // see RQ11
            lhist_reg  <= link_s & (lhist_reg | rd_stat);     // see RQ12
        end
    end

    // Auto-negotiation sequencer next state
    always_comb begin
        an_state_next = an_state_reg;
        case (an_state_reg)
            pbm_pkg::PBM_AN_OFF: begin
                if (an_kick) an_state_next = pbm_pkg::PBM_AN_RUN;
            end
            pbm_pkg::PBM_AN_RUN: begin
                if (!ane_reg) an_state_next = pbm_pkg::PBM_AN_OFF;
                else if (restart_reg) an_state_next = pbm_pkg::PBM_AN_RUN;
                else if (an_done_s) an_state_next = pbm_pkg::PBM_AN_DONE;
            end
            pbm_pkg::PBM_AN_DONE: begin
                if (!ane_reg) an_state_next = pbm_pkg::PBM_AN_OFF;
                else if (an_kick) an_state_next = pbm_pkg::PBM_AN_RUN;
            end
            default: an_state_next = pbm_pkg::PBM_AN_OFF;
        endcase
    end

    // Sequencer state register; soft reset aborts negotiation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) an_state_reg <= pbm_pkg::PBM_AN_OFF;
        else if (sw_reset) an_state_reg <= pbm_pkg::PBM_AN_OFF;
        else an_state_reg <= an_state_next; // see RQ4
    end

    wire an_complete = (an_state_reg == pbm_pkg::PBM_AN_DONE);

    // Read data assembly
    logic [pbm_pkg::REG_W-1:0] ctrl_rd;
    logic [pbm_pkg::REG_W-1:0] stat_rd;
    logic [pbm_pkg::REG_W-1:0] adv_rd;

    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[pbm_pkg::CTRL_SPEED]   = spd_reg;
        ctrl_rd[pbm_pkg::CTRL_ANE]     = ane_reg;
        ctrl_rd[pbm_pkg::CTRL_RESTART] = restart_reg;
        ctrl_rd[pbm_pkg::CTRL_DUPLEX]  = ane_reg ? res_dup_s : dup_reg; // see RQ8
        stat_rd = '0;
        stat_rd[pbm_pkg::STAT_ABIL_HI:pbm_pkg::STAT_ABIL_LO] =
            pbm_pkg::ABIL_VALUE;                       // see RQ9
        stat_rd[pbm_pkg::STAT_AN_DONE] = an_complete;  // see RQ10
        stat_rd[pbm_pkg::STAT_RFAULT]  = rfault_reg;
        stat_rd[pbm_pkg::STAT_LHIST]   = lhist_reg;
        stat_rd[pbm_pkg::STAT_LINK]    = link_s;       // see RQ13
        stat_rd[pbm_pkg::STAT_JABBER]  = jabber_s;     // see RQ14
        stat_rd[pbm_pkg::STAT_EXTCAP]  = 1'b1;         // see RQ15
        adv_rd = '0;                                   // see RQ16 RQ19
        adv_rd[pbm_pkg::ADV_RFAULT] = rfadv_reg;
        adv_rd[pbm_pkg::ADV_PAUSE]  = pause_reg;
        adv_rd[pbm_pkg::ADV_ABIL_HI:pbm_pkg::ADV_ABIL_LO] = abil_reg;
        adv_rd[pbm_pkg::ADV_SEL_HI:pbm_pkg::ADV_SEL_LO]   = sel_reg;
    end

    wire [pbm_pkg::REG_W-1:0] rd_mux = hit_ctrl ? ctrl_rd :
                                       hit_stat ? stat_rd :
                                       hit_adv  ? adv_rd  : '0;

    // APB answer: one wait state, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= access;
            pslverr <= access & ~hit_any;
            if (access & ~pwrite) prdata <= {16'h0000, rd_mux};
        end
    end

    // Link-side outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_100       <= 1'b0;
            full_duplex     <= 1'b0;
            autoneg_active  <= 1'b0;
            autoneg_restart <= 1'b0;
            phy_soft_reset  <= 1'b0;
            adv_word        <= '0;
        end else begin
            speed_100       <= ane_reg ? res_spd_s : spd_reg; // see RQ2 RQ5
            full_duplex     <= ane_reg ? res_dup_s : dup_reg; // see RQ5 RQ7
            autoneg_active  <= ane_reg;
            autoneg_restart <= an_kick & ~sw_reset;           // see RQ6
            phy_soft_reset  <= sw_reset;                      // see RQ1
            adv_word        <= adv_rd;                        // see RQ17 RQ20
        end
    end

    // Checks on the block's own behaviour
    a_soft_reset_load: assert property (@(posedge pclk) disable iff (!presetn)
        sw_reset |=> spd_reg == $past(dflt_spd_reg) && !restart_reg
            && ane_reg == $past(dflt_ane_reg) && phy_soft_reset) // see RQ1
        else $error("soft reset did not restore control defaults");

    a_speed_forced: assert property (@(posedge pclk) disable iff (!presetn)
        !ane_reg |=> speed_100 == $past(spd_reg)) // see RQ2
        else $error("forced speed does not follow speed bit");

    a_speed_autoneg: assert property (@(posedge pclk) disable iff (!presetn)
        ane_reg |=> speed_100 == $past(res_spd_s)) // see RQ4
        else $error("negotiated speed not taken from resolution");

    a_duplex_forced: assert property (@(posedge pclk) disable iff (!presetn)
        !ane_reg |=> full_duplex == $past(dup_reg)) // see RQ7
        else $error("forced duplex does not follow duplex bit");

    a_restart_kick: assert property (@(posedge pclk) disable iff (!presetn)
        ane_reg && restart_reg && !sw_reset |=> autoneg_restart
            && an_state_reg == pbm_pkg::PBM_AN_RUN) // see RQ6
        else $error("restart did not start negotiation");

    a_restart_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ane_reg && restart_reg && !wr_ctrl |=> !restart_reg) // see RQ22
        else $error("restart bit did not clear itself");

    a_dup_readback: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && hit_ctrl && ane_reg
            |=> prdata[pbm_pkg::CTRL_DUPLEX] == $past(res_dup_s)) // see RQ8
        else $error("duplex read does not show resolved status");

    a_stat_consts: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && hit_stat |=> prdata[15:11] == 5'h0F
            && prdata[pbm_pkg::STAT_EXTCAP]) // see RQ9
        else $error("status ability constants wrong");

    a_rfault_clear: assert property (@(posedge pclk) disable iff (!presetn)
        rd_stat && !rfault_s |=> !rfault_reg) // see RQ11
        else $error("remote fault not cleared on read");

    a_link_history: assert property (@(posedge pclk) disable iff (!presetn)
        !link_s && !sw_reset |=> !lhist_reg ##1 (lhist_reg || !rd_stat
            || !link_s || $past(rd_stat))) // see RQ12
        else $error("link fail history not latched");

    a_adv_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        adv_word[pbm_pkg::ADV_NEXTPG] == 1'b0 && adv_word[pbm_pkg::ADV_T4]
            == 1'b0 && adv_word[pbm_pkg::ADV_ACK] == 1'b0) // see RQ16
        else $error("fixed advertise bits not zero");

    a_an_complete: assert property (@(posedge pclk) disable iff (!presetn)
        an_state_reg == pbm_pkg::PBM_AN_RUN && ane_reg && !restart_reg
            && an_done_s && !sw_reset |=> an_complete) // see RQ10
        else $error("negotiation complete not reported");

    // Main scenarios
    c_soft_reset: cover property (@(posedge pclk) disable iff (!presetn)
        sw_reset ##1 phy_soft_reset);
    c_restart_done: cover property (@(posedge pclk) disable iff (!presetn)
        autoneg_restart ##[1:40] an_complete);
    c_rfault_read: cover property (@(posedge pclk) disable iff (!presetn)
        rfault_reg && rd_stat);

endmodule // pbm_regs

// ### pbm_pkg.sv
// Package: register map, field layout and reset values of the PHY mode regs
package pbm_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0]  CTRL_IDX     = 8'h62;
    localparam logic [7:0]  STAT_IDX     = 8'h64;
    localparam logic [7:0]  ADV_IDX      = 8'h66;
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam int          REG_W        = 16;

    // Control register field positions
    localparam int          CTRL_RESET   = 15;
    localparam int          CTRL_SPEED   = 13;
    localparam int          CTRL_ANE     = 12;
    localparam int          CTRL_RESTART = 9;
    localparam int          CTRL_DUPLEX  = 8;

    // Status register field positions
    localparam int          STAT_T4      = 15;
    localparam int          STAT_ABIL_HI = 14;
    localparam int          STAT_ABIL_LO = 11;
    localparam int          STAT_AN_DONE = 5;
    localparam int          STAT_RFAULT  = 4;
    localparam int          STAT_LHIST   = 3;
    localparam int          STAT_LINK    = 2;
    localparam int          STAT_JABBER  = 1;
    localparam int          STAT_EXTCAP  = 0;
    localparam logic [3:0]  ABIL_VALUE   = 4'hF;

    // Advertisement register field positions
    localparam int          ADV_NEXTPG   = 15;
    localparam int          ADV_ACK      = 14;
    localparam int          ADV_RFAULT   = 13;
    localparam int          ADV_PAUSE    = 10;
    localparam int          ADV_T4       = 9;
    localparam int          ADV_ABIL_HI  = 8;
    localparam int          ADV_ABIL_LO  = 5;
    localparam int          ADV_SEL_HI   = 4;
    localparam int          ADV_SEL_LO   = 0;
    localparam logic [3:0]  ADV_ABIL_RST = 4'hF;
    localparam logic [4:0]  ADV_SEL_RST  = 5'h01;

    // Width of the bundle of pin inputs passed through the synchroniser
    localparam int          SYNC_W       = 11;

    // Auto-negotiation sequencer states, one-hot
    typedef enum logic [2:0] {
        PBM_AN_OFF  = 3'h1,
        PBM_AN_RUN  = 3'h2,
        PBM_AN_DONE = 3'h4
    } pbm_an_state_t;

endpackage

// ### pbm_far_side.sv
// Far-side model: PHY core link levels and negotiation partner
`timescale 1ns/1ps

module pbm_far_side (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        link_cmd,
    input  wire logic        fault_cmd,
    input  wire logic        jab_cmd,
    input  wire logic        autoneg_restart,
    input  wire logic [15:0] adv_word,
    output logic             link_ok_in,
    output logic             jabber_in,
    output logic             remote_fault_in,
    output logic             an_done_in,
    output logic             res_speed_100_in,
    output logic             res_full_duplex_in
);
    logic [4:0] wait_cnt;

    // Link levels follow the bench; fault only if advertised
    assign link_ok_in      = link_cmd;
    assign jabber_in       = jab_cmd;
    assign remote_fault_in = fault_cmd & adv_word[13];

    // Restart drops done, resolves the offered abilities later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt           <= 5'h00;
            an_done_in         <= 1'b0;
            res_speed_100_in   <= 1'b0;
            res_full_duplex_in <= 1'b0;
        end else if (autoneg_restart) begin
            wait_cnt   <= 5'h14;
            an_done_in <= 1'b0;
        end else if (wait_cnt == 5'h01) begin
            wait_cnt           <= 5'h00;
            an_done_in         <= 1'b1;
            res_speed_100_in   <= adv_word[8] | adv_word[7];
            res_full_duplex_in <= adv_word[8] | (~adv_word[7] & adv_word[6]);
        end else if (wait_cnt != 5'h00) begin
            wait_cnt <= wait_cnt - 5'h01;
        end
    end
endmodule // pbm_far_side

// ### test_phy_basic_mode_regs.sv
// Self-checking bench for the PHY basic mode register block
`timescale 1ns/1ps

module test_phy_basic_mode_regs;
    localparam logic [11:0] CA   = {2'b00, pbm_pkg::CTRL_IDX, 2'b00};
    localparam logic [11:0] SA   = {2'b00, pbm_pkg::STAT_IDX, 2'b00};
    localparam logic [11:0] AA   = {2'b00, pbm_pkg::ADV_IDX, 2'b00};
    localparam logic [31:0] EE_C = 32'h00002100;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, c_m, a_m, d;
    logic        link_cmd, fault_cmd, jab_cmd, ee_load_done_in;
    logic [3:0]  ee_v;
    logic        link_ok_in, jabber_in, remote_fault_in, an_done_in;
    logic        res_speed_100_in, res_full_duplex_in;
    logic        speed_100, full_duplex, autoneg_active;
    logic        autoneg_restart, phy_soft_reset;
    logic [15:0] adv_word;
    int          mismatches, compares, cyc, rs_cnt, sr_cnt, i;
    integer      seed;

    pbm_regs pbm_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_ok_in(link_ok_in), .jabber_in(jabber_in),
        .remote_fault_in(remote_fault_in), .an_done_in(an_done_in),
        .res_speed_100_in(res_speed_100_in),
        .res_full_duplex_in(res_full_duplex_in),
        .ee_load_done_in(ee_load_done_in), .ee_speed_100_in(ee_v[3]),
        .ee_autoneg_in(ee_v[2]), .ee_full_duplex_in(ee_v[1]),
        .ee_pause_in(ee_v[0]),
        .speed_100(speed_100), .full_duplex(full_duplex),
        .autoneg_active(autoneg_active), .autoneg_restart(autoneg_restart),
        .phy_soft_reset(phy_soft_reset), .adv_word(adv_word));

    pbm_far_side pbm_far_side_inst (.pclk(pclk), .presetn(presetn),
        .link_cmd(link_cmd), .fault_cmd(fault_cmd), .jab_cmd(jab_cmd),
        .autoneg_restart(autoneg_restart), .adv_word(adv_word),
        .link_ok_in(link_ok_in), .jabber_in(jabber_in),
        .remote_fault_in(remote_fault_in), .an_done_in(an_done_in),
        .res_speed_100_in(res_speed_100_in),
        .res_full_duplex_in(res_full_duplex_in));

    // Clock, 5 ns period
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Pulse counters and hang guard
    always @(posedge pclk) begin
        cyc++;
        if (autoneg_restart === 1'b1) rs_cnt++;
        if (phy_soft_reset === 1'b1) sr_cnt++;
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [31:0] exp,
                          input logic [31:0] m = 32'hFFFFFFFF);
        cmp(r & m, exp & m);
    endtask

    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        cmp({16'h0000, got}, {16'h0000, exp});
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Writes that also update the reference model
    task automatic wc(input logic [31:0] wd);
        apb(1'b1, CA, wd);
        c_m = wd & 32'h00003100;
    endtask

    task automatic wa(input logic [31:0] wd);
        apb(1'b1, AA, wd);
        a_m = (wd & 32'h000021FF) | 32'h00000400;
    endtask

    function automatic logic [31:0] stat(input int an, rf, lh, lk, jb);
        return 32'h7801 | (an << 5) | (rf << 4) | (lh << 3) | (lk << 2)
            | (jb << 1);
    endfunction

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence
    initial begin
        seed = 32'hadda;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {fault_cmd, jab_cmd, ee_load_done_in} = 3'b000;
        ee_v = 4'hB;
        link_cmd = 1'b1;
        presetn  = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, CA, 32'h0);
        chk_rd(32'h0);
        apb(1'b0, SA, 32'h0);
        apb(1'b0, SA, 32'h0);
        chk_rd(stat(0, 0, 1, 1, 0));
        apb(1'b0, AA, 32'h0);
        chk_rd(32'h01E1);
        chk_pin(adv_word, 16'h01E1);
        $display("test reset done");
        ee_load_done_in <= 1'b1;
        repeat (6) @(posedge pclk);
        c_m = EE_C;
        a_m = 32'h05E1;
        apb(1'b0, CA, 32'h0);
        chk_rd(c_m);
        apb(1'b0, AA, 32'h0);
        chk_rd(a_m);
        $display("test eeprom done");
        for (i = 0; i < 4; i++) begin
            wc((i[1] << 13) | (i[0] << 8) | 32'h00000200);
            repeat (6) @(posedge pclk);
            apb(1'b0, CA, 32'h0);
            chk_rd(c_m);
            chk_pin({autoneg_active, speed_100, full_duplex}, 16'(i));
        end
        $display("test forced mode done");
        for (i = 0; i < 3; i++) begin
            d = $random(seed);
            wa(d);
            apb(1'b0, AA, 32'h0);
            chk_rd(a_m);
            chk_pin(adv_word, a_m[15:0]);
        end
        $display("test advertise done");
        wa(32'h2021);
        wc(32'h3100);
        repeat (40) @(posedge pclk);
        apb(1'b0, SA, 32'h0);
        chk_rd(stat(1, 0, 1, 1, 0));
        apb(1'b0, CA, 32'h0);
        chk_rd(32'h3000);
        chk_pin({autoneg_active, speed_100, full_duplex}, 16'h4);
        wa(32'h2101);
        wc(32'h3300);
        repeat (40) @(posedge pclk);
        apb(1'b0, CA, 32'h0);
        chk_rd(32'h3100);
        chk_pin({speed_100, full_duplex}, 16'h3);
        cmp(rs_cnt, 2);
        $display("test autoneg done");
        fault_cmd <= 1'b1;
        repeat (4) @(posedge pclk);
        fault_cmd <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, SA, 32'h0);
        chk_rd(stat(1, 1, 1, 1, 0));
        apb(1'b0, SA, 32'h0);
        chk_rd(stat(1, 0, 1, 1, 0));
        link_cmd <= 1'b0;
        jab_cmd  <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, SA, 32'h0);
        chk_rd(stat(1, 0, 0, 0, 1), 32'hFFDF);
        link_cmd <= 1'b1;
        jab_cmd  <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, SA, 32'h0);
        apb(1'b0, SA, 32'h0);
        chk_rd(stat(1, 0, 1, 1, 0), 32'hFFDF);
        $display("test status done");
        apb(1'b0, 12'h000, 32'h0);
        cmp({31'h0, e}, 32'h1);
        chk_rd(32'h0);
        $display("test unmapped done");
        // Pins move after capture; soft reset must keep captured defaults
        ee_v <= 4'h4;
        apb(1'b1, CA, 32'h8000);
        c_m = EE_C;
        a_m = 32'h05E1;
        repeat (6) @(posedge pclk);
        apb(1'b0, CA, 32'h0);
        chk_rd(c_m);
        apb(1'b0, AA, 32'h0);
        chk_rd(a_m);
        cmp(sr_cnt, 1);
        chk_pin({autoneg_active, speed_100, full_duplex}, 16'h3);
        $display("test soft reset done");
        close_out();
    end
endmodule // test_phy_basic_mode_regs
